/* logic/ubef_pkg.sv */
// package for the usb bus event flag block: register map, bit layout,
// line timing and line state codes.
// assumes a 25 MHz register clock and 32-bit apb data.
package ubef_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_FLAGS = 8'h00;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
   localparam logic [7:0] OFS_ERR_ENABLE = 8'h08;
   localparam logic [7:0] OFS_ERR_STATUS = 8'h0c;
   localparam logic [7:0] OFS_CONTROL = 8'h10;

   // ----------------------------------------------------------------
   // event flag bit positions
   // ----------------------------------------------------------------
   localparam int BIT_BUS_RESET = 0;
   localparam int BIT_DETACH = 0;
   localparam int BIT_ERROR = 1;
   localparam int BIT_FRAME_START = 2;
   localparam int BIT_TRN_DONE = 3;
   localparam int BIT_IDLE = 4;
   localparam int BIT_RESUME = 5;
   localparam int BIT_ATTACH = 6;
   localparam int BIT_STALL = 7;
   localparam int FLAG_W = 8;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;

   // control register fields
   localparam int CTL_HOST_MODE = 0;
   localparam int CTL_LOW_SPEED = 1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int LINE_HOLD_NS = 2500;
   localparam int IDLE_HOLD_US = 3000;
   // least times round up to whole cycles
   localparam int LINE_HOLD_CYC =
      (LINE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_HOLD_CYC =
      (IDLE_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // line states, decoded from the synchronised data lines
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      LINE_SE0 = 2'b00,
      LINE_J = 2'b01,
      LINE_K = 2'b10,
      LINE_SE1 = 2'b11
   } ubef_line_e;

endpackage : ubef_pkg

/* logic/ubef_flags.sv */
// usb bus event flag register with line-state detectors and apb slave.
// assumes dp/dm arrive from pins (asynchronous) and the event pulses
// come from usb engine logic on pclk.
//
// Notes on behaviour
// - frame start sets bit 2 on a received frame token in device mode or on the frame threshold in host mode.
// - error summary at bit 1 is read only, ignores writes and follows the error conditions.
// - error summary rises only for error conditions whose enable bit is set.
// - in device mode bit 0 sets once a bus reset has lasted 2.5 us.
// - a continuous bus reset sets bit 0 only once; the line must leave reset first.
// - writing one to a hardware set flag clears it, writing zero leaves it.
// - bits 31 to 8 read as zero.
// - host layout is stall, attach, resume, idle, done, frame start, error, detach; all reset to zero.
// - bit 7 sets when a stall handshake is sent.
// - in host mode bit 6 sets when the line is not se0 and quiet for 2.5 us.
// - bit 5 sets when a k state lasts 2.5 us, speed choosing the k polarity.
// - bit 4 sets when the line stays idle for 3 ms.
// - device layout puts reset at 0 and leaves bit 6 unimplemented.
// - clearing the transaction done flag advances the status queue.
`timescale 1ns/100ps
module ubef_flags #(
   parameter int ERR_W = 8,
   parameter int CNT_W = 17,
   parameter int IDLE_CYCLES = ubef_pkg::IDLE_HOLD_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // usb data lines
   input wire logic usb_dp,
   input wire logic usb_dm,
   // events from the usb engine, one-cycle pulses
   input wire logic stall_sent,
   input wire logic sof_token,
   input wire logic sof_threshold,
   input wire logic trn_done,
   input wire logic detach_seen,
   input wire logic [ERR_W-1:0] err_event,
   // outputs
   output logic stat_advance,
   output logic irq
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (ERR_W < 1 || ERR_W > 16) begin : g_chk_err
      $error("ERR_W must be 1 to 16");
   end
   if (IDLE_CYCLES < ubef_pkg::LINE_HOLD_CYC ||
       IDLE_CYCLES >= (1 << CNT_W) - 1) begin : g_chk_cnt
      $error("IDLE_CYCLES must fit CNT_W and exceed line hold");
   end
   if (CNT_W < 1 || CNT_W > 30) begin : g_chk_w
      $error("CNT_W must be 1 to 30");
   end

   localparam logic [CNT_W-1:0] HOLD_END =
      CNT_W'(ubef_pkg::LINE_HOLD_CYC - 1);
   localparam logic [CNT_W-1:0] IDLE_END = CNT_W'(IDLE_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [ubef_pkg::FLAG_W-1:0] flags;
   logic [ubef_pkg::FLAG_W-1:0] irq_mask;
   logic [ERR_W-1:0] err_enable;
   logic [ERR_W-1:0] err_status;
   logic host_mode;
   logic low_speed;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire sel_flags = paddr == ubef_pkg::OFS_FLAGS;
   wire sel_mask = paddr == ubef_pkg::OFS_IRQ_MASK;
   wire sel_een = paddr == ubef_pkg::OFS_ERR_ENABLE;
   wire sel_est = paddr == ubef_pkg::OFS_ERR_STATUS;
   wire sel_ctl = paddr == ubef_pkg::OFS_CONTROL;
   wire mapped = sel_flags | sel_mask | sel_een | sel_est | sel_ctl;
   wire wr = access & pwrite & mapped;
   wire wr_flags = wr & sel_flags;
   wire wr_mask = wr & sel_mask;
   wire wr_een = wr & sel_een;
   wire wr_est = wr & sel_est;
   wire wr_ctl = wr & sel_ctl;

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // ----------------------------------------------------------------
   // line synchroniser and state decode
   // ----------------------------------------------------------------
   // pins are asynchronous; only the second stage feeds logic
   logic dp_meta;
   logic dp_sync;
   logic dm_meta;
   logic dm_sync;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dp_meta <= 1'b0;
         dp_sync <= 1'b0;
         dm_meta <= 1'b0;
         dm_sync <= 1'b0;
      end else begin
         dp_meta <= usb_dp;
         dp_sync <= dp_meta;
         dm_meta <= usb_dm;
         dm_sync <= dm_meta;
      end
   end

   // differential one is dp high; j is differential one at full speed
   wire diff_one = dp_sync & ~dm_sync;
   wire diff_zero = ~dp_sync & dm_sync;
   wire is_j = low_speed ? diff_zero : diff_one;
   wire is_k = low_speed ? diff_one : diff_zero;
   ubef_pkg::ubef_line_e line_now;
   assign line_now = (~dp_sync & ~dm_sync) ? ubef_pkg::LINE_SE0 :
                     is_j ? ubef_pkg::LINE_J :
                     is_k ? ubef_pkg::LINE_K : ubef_pkg::LINE_SE1;

   // ----------------------------------------------------------------
   // line stability counter: cycles the line state has held
   // ----------------------------------------------------------------
   ubef_pkg::ubef_line_e line_prev;
   logic [CNT_W-1:0] hold_cnt;
   wire line_moved = line_now != line_prev;
   wire [CNT_W-1:0] next_hold_cnt =
      line_moved ? '0 :
      (hold_cnt == CNT_MAX) ? hold_cnt : hold_cnt + 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_prev <= ubef_pkg::LINE_SE0;
         hold_cnt <= '0;
      end else begin
         line_prev <= line_now;
         hold_cnt <= next_hold_cnt;
      end
   end

   // each detector fires once, at the exact cycle the hold is reached;
   // the count only returns there after the line state has changed
   wire held_line = ~line_moved & (hold_cnt == HOLD_END);
   wire held_idle = ~line_moved & (hold_cnt == IDLE_END);
   wire in_se0 = line_now == ubef_pkg::LINE_SE0;
   wire in_k = line_now == ubef_pkg::LINE_K;
   wire in_j = line_now == ubef_pkg::LINE_J;
   wire det_reset = ~host_mode & in_se0 & held_line;
   wire det_attach = host_mode & ~in_se0 & held_line;
   wire det_resume = in_k & held_line;
   wire det_idle = in_j & held_idle;

   // ----------------------------------------------------------------
   // flag set sources per mode
   // ----------------------------------------------------------------
   logic [ubef_pkg::FLAG_W-1:0] flag_set;
   always_comb begin
      flag_set = '0;
      flag_set[ubef_pkg::BIT_STALL] = stall_sent;
      flag_set[ubef_pkg::BIT_ATTACH] = det_attach;
      flag_set[ubef_pkg::BIT_RESUME] = det_resume;
      flag_set[ubef_pkg::BIT_IDLE] = det_idle;
      flag_set[ubef_pkg::BIT_TRN_DONE] = trn_done;
      flag_set[ubef_pkg::BIT_FRAME_START] =
         host_mode ? sof_threshold : sof_token;
      // bit 0 is detach in host mode and bus reset in device mode
      if (host_mode) begin
         flag_set[ubef_pkg::BIT_DETACH] = detach_seen;
      end else begin
         flag_set[ubef_pkg::BIT_BUS_RESET] = det_reset;
      end
   end

   wire [ubef_pkg::FLAG_W-1:0] flag_clr =
      wr_flags ? pwdata[ubef_pkg::FLAG_W-1:0] : '0;
   logic [ubef_pkg::FLAG_W-1:0] next_flags;

   // ----------------------------------------------------------------
   // sticky flags, one per bit; bit 1 is not stored
   // ----------------------------------------------------------------
   for (genvar i = 0; i < ubef_pkg::FLAG_W; i++) begin : g_flag
      if (i == ubef_pkg::BIT_ERROR) begin : g_ro
         assign next_flags[i] = 1'b0;
      end else begin : g_w1c
         // set wins over a clear in the same cycle
         assign next_flags[i] =
            (flags[i] & ~flag_clr[i]) | flag_set[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= ubef_pkg::FLAGS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   // ----------------------------------------------------------------
   // individual error conditions and the summary
   // ----------------------------------------------------------------
   wire [ERR_W-1:0] err_clr = wr_est ? pwdata[ERR_W-1:0] : '0;
   wire [ERR_W-1:0] next_err_status =
      (err_status & ~err_clr) | err_event;
   wire err_summary = |(err_status & err_enable);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_status <= '0;
      end else begin
         err_status <= next_err_status;
      end
   end

   // ----------------------------------------------------------------
   // status queue advance on clearing a set transaction done flag
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_advance <= 1'b0;
      end else begin
         stat_advance <= flags[ubef_pkg::BIT_TRN_DONE] &
                         flag_clr[ubef_pkg::BIT_TRN_DONE];
      end
   end

   // ----------------------------------------------------------------
   // software control registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= '0;
         err_enable <= '0;
         host_mode <= 1'b0;
         low_speed <= 1'b0;
      end else begin
         if (wr_mask) begin
            irq_mask <= pwdata[ubef_pkg::FLAG_W-1:0];
         end
         if (wr_een) begin
            err_enable <= pwdata[ERR_W-1:0];
         end
         if (wr_ctl) begin
            host_mode <= pwdata[ubef_pkg::CTL_HOST_MODE];
            low_speed <= pwdata[ubef_pkg::CTL_LOW_SPEED];
         end
      end
   end

   // ----------------------------------------------------------------
   // read view and interrupt
   // ----------------------------------------------------------------
   logic [ubef_pkg::FLAG_W-1:0] flags_view;
   always_comb begin
      flags_view = flags;
      flags_view[ubef_pkg::BIT_ERROR] = err_summary;
      if (!host_mode) begin
         flags_view[ubef_pkg::BIT_ATTACH] = 1'b0;
      end
   end

   wire [31:0] rd_flags = {24'h000000, flags_view};
   wire [31:0] rd_mask = {24'h000000, irq_mask};
   wire [31:0] rd_een = {{(32 - ERR_W){1'b0}}, err_enable};
   wire [31:0] rd_est = {{(32 - ERR_W){1'b0}}, err_status};
   wire [31:0] rd_ctl = {30'h0, low_speed, host_mode};
   wire [31:0] rd_mux =
      sel_flags ? rd_flags :
      sel_mask ? rd_mask :
      sel_een ? rd_een :
      sel_est ? rd_est :
      sel_ctl ? rd_ctl : 32'h00000000;

   // read data is captured in the setup cycle and held through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup & ~pwrite) begin
         prdata <= rd_mux;
      end
   end

   assign irq = |(flags_view & irq_mask);

endmodule : ubef_flags

/* verification/ubef_usb_far.sv */
// far-side line model: turns a requested line state into d+ and d-.
// assumes the bench picks the state and the bus speed.
`timescale 1ns/100ps
module ubef_usb_far (
   // requested line state
   input wire ubef_pkg::ubef_line_e state,
   input wire logic low_speed,
   // data lines
   output logic dp,
   output logic dm
);
   wire logic jk = state == ubef_pkg::LINE_J || state == ubef_pkg::LINE_K;
   // j is dp high at full speed, swapped at low speed
   assign dp = (state == ubef_pkg::LINE_SE1) |
      ((state == ubef_pkg::LINE_J) ^ (low_speed & jk));
   assign dm = (state == ubef_pkg::LINE_SE1) |
      ((state == ubef_pkg::LINE_K) ^ (low_speed & jk));
endmodule : ubef_usb_far

/* verification/ubef_flags_sva.sv */
// checker for the event flag block: apb answers and advance pulse.
// bound to every ubef_flags instance; sees only its ports.
`timescale 1ns/100ps
module ubef_flags_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // queue advance
   input wire logic stat_advance
);
   wire logic hit = paddr inside {ubef_pkg::OFS_FLAGS, ubef_pkg::OFS_IRQ_MASK,
      ubef_pkg::OFS_ERR_ENABLE, ubef_pkg::OFS_ERR_STATUS,
      ubef_pkg::OFS_CONTROL};
   wire logic rd_setup = psel & ~penable & ~pwrite;
   wire logic fl = paddr == ubef_pkg::OFS_FLAGS;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_high_a: assert property (pready) else $error("pready low");
   unmapped_err_a: assert property (psel && penable && !hit |-> pslverr)
      else $error("no error on unmapped access");
   err_cause_a: assert property (pslverr |-> psel && penable && !hit)
      else $error("spurious pslverr");
   upper_zero_a: assert property (rd_setup && fl |=> prdata[31:8] == 24'h0)
      else $error("flag upper bits not zero");
   unmapped_zero_a: assert property (rd_setup && !hit |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   read_hold_a: assert property (!rd_setup |=> $stable(prdata))
      else $error("prdata moved outside read setup");
   adv_cause_a: assert property (stat_advance |->
      $past(psel && penable && pwrite && fl &&
      pwdata[ubef_pkg::BIT_TRN_DONE]))
      else $error("advance without done clear");
   adv_pulse_a: assert property (stat_advance |=> !stat_advance)
      else $error("advance longer than one cycle");
endmodule : ubef_flags_sva
bind ubef_flags ubef_flags_sva chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .stat_advance(stat_advance));

/* verification/tb_usb_bus_event_flags.sv */
// self-checking bench for ubef_flags: apb register tests and line
// tests through the far-side model; idle count shortened to 200.
`timescale 1ns/100ps
module tb_usb_bus_event_flags;
   localparam logic [7:0] a_fl = ubef_pkg::OFS_FLAGS;
   localparam logic [7:0] a_mk = ubef_pkg::OFS_IRQ_MASK;
   localparam logic [7:0] a_ct = ubef_pkg::OFS_CONTROL;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, usb_dp, usb_dm, stat_advance, irq;
   logic [4:0] ev = 5'h00;
   logic [7:0] err = 8'h00;
   logic low_spd = 1'b0;
   ubef_pkg::ubef_line_e line = ubef_pkg::LINE_SE1;
   int bad_count = 0;
   int samples_checked = 0;
   always #20 pclk = ~pclk;
   ubef_flags #(.IDLE_CYCLES(200)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .usb_dp(usb_dp), .usb_dm(usb_dm), .stall_sent(ev[0]),
      .sof_token(ev[1]), .sof_threshold(ev[2]), .trn_done(ev[3]),
      .detach_seen(ev[4]), .err_event(err), .stat_advance(stat_advance),
      .irq(irq));
   ubef_usb_far far_u (.state(line), .low_speed(low_spd), .dp(usb_dp),
      .dm(usb_dm));
   // ----------------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk
   // ev pulses during the access cycle, landing on the write edge
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [4:0] e, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      ev <= e;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      ev <= 5'h00;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, 5'h00, q);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, 5'h00, q);
      chk(exp, q);
   endtask : rdc
   task automatic pulse(input logic [4:0] e, input logic [7:0] r);
      @(posedge pclk);
      ev <= e;
      err <= r;
      @(posedge pclk);
      ev <= 5'h00;
      err <= 8'h00;
   endtask : pulse
   task automatic pin(input logic exp);
      @(negedge pclk);
      chk({31'h0, exp}, {31'h0, irq});
   endtask : pin
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      rdc(a_fl, 32'h0);
      rdc(8'h14, 32'h0);
      wr(a_mk, 32'h80);
      rdc(a_mk, 32'h80);
      pulse(5'h01, 8'h00);
      rdc(a_fl, 32'h80);
      pin(1'b1);
      wr(a_fl, 32'h7f);
      rdc(a_fl, 32'h80);
      wr(a_fl, 32'h80);
      rdc(a_fl, 32'h0);
      pin(1'b0);
      pulse(5'h02, 8'h00);
      rdc(a_fl, 32'h04);
      pin(1'b0);
      wr(a_fl, 32'h04);
      $display("test regs done");
   endtask : t_regs
   task automatic t_race();
      logic [31:0] q;
      pulse(5'h01, 8'h00);
      xfer(1'b1, a_fl, 32'h80, 5'h01, q);
      rdc(a_fl, 32'h80);
      wr(a_fl, 32'h80);
      pulse(5'h08, 8'h00);
      wr(a_fl, 32'h08);
      @(negedge pclk);
      chk(32'h1, {31'h0, stat_advance});
      $display("test race done");
   endtask : t_race
   task automatic t_err();
      wr(ubef_pkg::OFS_ERR_ENABLE, 32'h01);
      rdc(ubef_pkg::OFS_ERR_ENABLE, 32'h01);
      pulse(5'h00, 8'h02);
      rdc(a_fl, 32'h0);
      pulse(5'h00, 8'h01);
      rdc(ubef_pkg::OFS_ERR_STATUS, 32'h03);
      rdc(a_fl, 32'h02);
      wr(a_fl, 32'h02);
      rdc(a_fl, 32'h02);
      wr(ubef_pkg::OFS_ERR_STATUS, 32'h03);
      rdc(a_fl, 32'h0);
      $display("test err done");
   endtask : t_err
   task automatic t_line_dev();
      line <= ubef_pkg::LINE_SE0;
      repeat (40) @(posedge pclk);
      rdc(a_fl, 32'h0);
      repeat (40) @(posedge pclk);
      rdc(a_fl, 32'h01);
      wr(a_fl, 32'h01);
      repeat (100) @(posedge pclk);
      rdc(a_fl, 32'h0);
      line <= ubef_pkg::LINE_K;
      repeat (100) @(posedge pclk);
      rdc(a_fl, 32'h20);
      line <= ubef_pkg::LINE_SE0;
      repeat (100) @(posedge pclk);
      rdc(a_fl, 32'h21);
      line <= ubef_pkg::LINE_SE1;
      wr(a_fl, 32'hff);
      $display("test line device done");
   endtask : t_line_dev
   task automatic t_line_host();
      wr(a_ct, 32'h01);
      line <= ubef_pkg::LINE_J;
      repeat (300) @(posedge pclk);
      rdc(a_fl, 32'h50);
      pulse(5'h14, 8'h00);
      rdc(a_fl, 32'h55);
      wr(a_fl, 32'hff);
      rdc(a_fl, 32'h0);
      wr(a_ct, 32'h03);
      rdc(a_ct, 32'h03);
      low_spd <= 1'b1;
      line <= ubef_pkg::LINE_K;
      repeat (100) @(posedge pclk);
      rdc(a_fl, 32'h60);
      wr(a_ct, 32'h00);
      rdc(a_fl, 32'h20);
      $display("test line host done");
   endtask : t_line_host
   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_race();
      t_err();
      t_line_dev();
      t_line_host();
      summarize();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      summarize();
   end
endmodule : tb_usb_bus_event_flags
